// >>> common/tcp_pkg.sv
package tcp_pkg;

  // Register offsets (byte addresses, one word each)
  localparam logic [7:0] OFF_CONTROL_ONE = 8'h00;
  localparam logic [7:0] OFF_CONTROL_TWO = 8'h04;
  localparam logic [7:0] OFF_STATUS = 8'h08;
  localparam logic [7:0] OFF_CMP1_HIGH = 8'h0C;
  localparam logic [7:0] OFF_CMP1_LOW = 8'h10;
  localparam logic [7:0] OFF_CMP2_HIGH = 8'h14;
  localparam logic [7:0] OFF_CMP2_LOW = 8'h18;

  // Reset and load values
  localparam logic [15:0] CMP_RESET = 16'h8000;
  localparam logic [15:0] CNT_RELOAD = 16'hFFFC;
  localparam logic [15:0] CAP_PULSE_LOAD = 16'hFFFD;
  localparam logic [7:0] CTL_ONE_RESET = 8'h00;
  localparam logic [3:0] CTL_TWO_RESET = 4'h0;

  // Control one layout, bit 7 down to bit 0
  typedef struct packed {
    logic cap_irq_en;
    logic cmp_irq_en;
    logic spare;
    logic force_two;
    logic force_one;
    logic level_two;
    logic edge_sel_one;
    logic level_one;
  } tcp_ctl_one_t;

  // Control two layout, bit 3 down to bit 0
  typedef struct packed {
    logic pwm_select;
    logic single_pulse_select;
    logic pin_en_two;
    logic pin_en_one;
  } tcp_ctl_two_t;

  // Load strobe with its value
  typedef struct packed {
    logic load;
    logic [15:0] value;
  } tcp_load_t;

  typedef enum logic [2:0] {
    TCP_MODE_NORMAL = 3'h1,
    TCP_MODE_PULSE = 3'h2,
    TCP_MODE_PWM = 3'h4
  } tcp_mode_t;

endpackage

// >>> rtl/tcp_timer_compare.sv
`timescale 1ns/1ps
module tcp_timer_compare #(
  parameter int ADDR_W = 8
) (
  input wire logic clk,                       // System clock
  input wire logic sys_rst,                   // Async reset, high
  input wire logic psel,                      // APB select
  input wire logic penable,                   // APB enable
  input wire logic pwrite,                    // APB direction
  input wire logic [ADDR_W-1:0] paddr,        // APB byte address
  input wire logic [31:0] pwdata,             // APB write data
  input wire logic [3:0] pstrb,               // APB byte strobes
  output logic [31:0] prdata,                 // APB read data
  output logic pready,                        // APB ready
  output logic pslverr,                       // APB error
  input wire logic timer_tick,                // One timer clock cycle
  input wire logic [15:0] counter_value,      // Free running count
  input wire logic capture_pin_one_edge,      // Valid edge, pin one
  input wire logic capture_flag_one,          // Capture flag one state
  input wire logic irq_mask,                  // Global mask, high masks
  output logic capture_edge_select_one,       // Edge choice for pin one
  output tcp_pkg::tcp_load_t counter_reload,  // Counter reload strobe
  output tcp_pkg::tcp_load_t capture_one_load,// Capture one load strobe
  output logic capture_one_set,               // Set capture flag one
  output logic capture_one_disable,           // Stop captures on pin one
  output logic [1:0] compare_output_pin,      // Compare pin levels
  output logic [1:0] compare_pin_drive,       // Compare pin enables
  output logic timer_irq                      // Timer interrupt request
);

  // Address match helper
  function automatic logic is_hit(input logic [ADDR_W-1:0] a,
                                  input logic [7:0] off);
    is_hit = (a == ADDR_W'(off));
  endfunction

  tcp_pkg::tcp_ctl_one_t ctl1;
  tcp_pkg::tcp_ctl_two_t ctl2;
  tcp_pkg::tcp_mode_t mode;
  logic [15:0] cmp_val [2];
  logic [15:0] active [2];
  logic [15:0] next_active [2];
  logic [1:0] inhibit;
  logic [1:0] flag;
  logic [1:0] armed;
  logic [1:0] pin;
  logic [1:0] next_inhibit;
  logic [1:0] next_flag;
  logic [1:0] next_armed;
  logic [1:0] next_pin;
  logic [31:0] next_prdata;

  // APB phase and decode
  wire setup = psel & ~penable;
  wire access = psel & penable;
  wire wr = access & pwrite & pstrb[0];
  wire rd = access & ~pwrite;
  wire hit_ctl1 = is_hit(paddr, tcp_pkg::OFF_CONTROL_ONE);
  wire hit_ctl2 = is_hit(paddr, tcp_pkg::OFF_CONTROL_TWO);
  wire hit_stat = is_hit(paddr, tcp_pkg::OFF_STATUS);
  wire [1:0] hit_hi = {is_hit(paddr, tcp_pkg::OFF_CMP2_HIGH),
                       is_hit(paddr, tcp_pkg::OFF_CMP1_HIGH)};
  wire [1:0] hit_lo = {is_hit(paddr, tcp_pkg::OFF_CMP2_LOW),
                       is_hit(paddr, tcp_pkg::OFF_CMP1_LOW)};
  wire mapped = hit_ctl1 | hit_ctl2 | hit_stat | (|hit_hi) | (|hit_lo);
  wire [1:0] hi_wr = hit_hi & {2{wr}};
  wire [1:0] lo_wr = hit_lo & {2{wr}};
  wire [1:0] lo_acc = hit_lo & {2{access}};
  wire stat_rd = rd & hit_stat;

  // Zero wait state slave, error on unmapped access
  assign pready = 1'b1;
  assign pslverr = access & ~mapped;

  // Mode select, PWM takes precedence
  assign mode = ctl2.pwm_select ? tcp_pkg::TCP_MODE_PWM :
                ctl2.single_pulse_select ? tcp_pkg::TCP_MODE_PULSE :
                tcp_pkg::TCP_MODE_NORMAL;
  wire is_normal = (mode == tcp_pkg::TCP_MODE_NORMAL);
  wire is_pulse = (mode == tcp_pkg::TCP_MODE_PULSE);
  wire is_pwm = (mode == tcp_pkg::TCP_MODE_PWM);

  // Compare against the running count each timer tick
  wire [1:0] match;
  assign match[0] = timer_tick & (counter_value == active[0])
                    & ~inhibit[0];
  assign match[1] = timer_tick & (counter_value == active[1])
                    & ~inhibit[1];
  wire pulse_trig = is_pulse & capture_pin_one_edge;
  wire period_end = is_pwm & match[1];

  // Flags set outside PWM; flag one never in pulse mode
  wire [1:0] set_flag = {match[1] & ~is_pwm,
                         match[0] & is_normal};
  wire [1:0] clr_flag = armed & lo_acc;

  // Flag, arm and inhibit next values; set wins over clear
  assign next_flag = set_flag | (flag & ~clr_flag);
  assign next_armed = ({2{stat_rd}} & flag) | (armed & ~lo_acc);
  assign next_inhibit = hi_wr | (inhibit & ~lo_wr);

  // Working compare values, buffered in PWM until period end
  always_comb begin
    for (int i = 0; i < 2; i++) begin
      if (!is_pwm || period_end) begin
        next_active[i] = cmp_val[i];
      end else begin
        next_active[i] = active[i];
      end
    end
  end

  // Compare pin levels by mode
  always_comb begin
    next_pin = pin;
    unique case (mode)
      tcp_pkg::TCP_MODE_NORMAL: begin
        if (ctl2.pin_en_one && (match[0] || ctl1.force_one)) begin
          next_pin[0] = ctl1.level_one;
        end
        if (ctl2.pin_en_two && (match[1] || ctl1.force_two)) begin
          next_pin[1] = ctl1.level_two;
        end
      end
      tcp_pkg::TCP_MODE_PULSE: begin
        if (ctl2.pin_en_one && pulse_trig) begin
          next_pin[0] = ctl1.level_two;
        end else if (ctl2.pin_en_one && match[0]) begin
          next_pin[0] = ctl1.level_one;
        end
      end
      tcp_pkg::TCP_MODE_PWM: begin
        if (ctl2.pin_en_one && match[1]) begin
          next_pin[0] = ctl1.level_two;
        end else if (ctl2.pin_en_one && match[0]) begin
          next_pin[0] = ctl1.level_one;
        end
      end
    endcase
  end

  // Read data mux, sampled in the setup phase
  always_comb begin
    next_prdata = 32'h0000_0000;
    if (hit_ctl1) begin
      next_prdata[7:0] = ctl1;
    end else if (hit_ctl2) begin
      next_prdata[3:0] = ctl2;
    end else if (hit_stat) begin
      next_prdata[1:0] = flag;
    end else if (hit_hi[0]) begin
      next_prdata[7:0] = cmp_val[0][15:8];
    end else if (hit_lo[0]) begin
      next_prdata[7:0] = cmp_val[0][7:0];
    end else if (hit_hi[1]) begin
      next_prdata[7:0] = cmp_val[1][15:8];
    end else if (hit_lo[1]) begin
      next_prdata[7:0] = cmp_val[1][7:0];
    end
  end

  // Control registers
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      ctl1 <= tcp_pkg::CTL_ONE_RESET;
      ctl2 <= tcp_pkg::CTL_TWO_RESET;
    end else begin
      if (wr && hit_ctl1) begin
        ctl1 <= {pwdata[7:6], 1'b0, pwdata[4:0]};
      end
      if (wr && hit_ctl2) begin
        ctl2 <= pwdata[3:0];
      end
    end
  end

  // Compare value registers, written only by software
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      cmp_val[0] <= tcp_pkg::CMP_RESET;
      cmp_val[1] <= tcp_pkg::CMP_RESET;
    end else begin
      for (int i = 0; i < 2; i++) begin
        if (hi_wr[i]) begin
          cmp_val[i][15:8] <= pwdata[7:0];
        end
        if (lo_wr[i]) begin
          cmp_val[i][7:0] <= pwdata[7:0];
        end
      end
    end
  end

  // Working compare values
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      active[0] <= tcp_pkg::CMP_RESET;
      active[1] <= tcp_pkg::CMP_RESET;
    end else begin
      active[0] <= next_active[0];
      active[1] <= next_active[1];
    end
  end

  // Flag, arm, inhibit, pin and read data state
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      flag <= 2'h0;
      armed <= 2'h0;
      inhibit <= 2'h0;
      pin <= 2'h0;
      prdata <= 32'h0000_0000;
    end else begin
      flag <= next_flag;
      armed <= next_armed;
      inhibit <= next_inhibit;
      pin <= next_pin;
      if (setup) begin
        prdata <= next_prdata;
      end
    end
  end

  // Pin outputs; a disabled pin stays general I/O
  assign compare_output_pin = pin;
  assign compare_pin_drive = {ctl2.pin_en_two, ctl2.pin_en_one};

  // Links to counter and capture sections
  assign capture_edge_select_one = ctl1.edge_sel_one;
  assign capture_one_disable = ~is_normal;
  assign counter_reload.load = pulse_trig | period_end;
  assign counter_reload.value = tcp_pkg::CNT_RELOAD;
  assign capture_one_load.load = pulse_trig;
  assign capture_one_load.value = tcp_pkg::CAP_PULSE_LOAD;
  assign capture_one_set = pulse_trig | period_end;

  // Interrupt request, gated by the global mask
  assign timer_irq = ~irq_mask & ((ctl1.cmp_irq_en & (|flag))
                     | (ctl1.cap_irq_en & capture_flag_one));

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (sys_rst);

  a_match_sets_flag: assert property (
    (match[0] && is_normal) |=> flag[0])
    else $error("compare match did not set flag one");

  a_irq_mask_gate: assert property (
    timer_irq |-> (!irq_mask && (ctl1.cmp_irq_en || ctl1.cap_irq_en)))
    else $error("interrupt raised while masked or disabled");

  a_flag_clear_seq: assert property (
    $fell(flag[0]) |-> $past(armed[0] && lo_acc[0]))
    else $error("flag one cleared without read sequence");

  a_inhibit_hold: assert property (
    (hi_wr[1] && !lo_wr[1] && !match[1]) |=> (!flag[1] || $past(flag[1]))
    throughout (inhibit[1] [*2]))
    else $error("compare two fired while inhibited");

  a_cmp_sw_only: assert property (
    !$stable(cmp_val[0]) |-> $past(hi_wr[0] || lo_wr[0]))
    else $error("compare value one changed without write");

  a_pin_disabled: assert property (
    !ctl2.pin_en_one |=> $stable(pin[0]))
    else $error("disabled compare pin one changed");

  a_force_no_flag: assert property (
    (ctl1.force_one && !match[0] && !flag[0] && !is_pwm)
    |=> !flag[0])
    else $error("forced output set a flag");

  a_modes_block_force: assert property (
    (!is_normal && !match[0] && !match[1] && !pulse_trig)
    |=> $stable(pin[0]))
    else $error("pin one moved without a mode event");

  a_pulse_trigger: assert property (
    (pulse_trig && ctl2.pin_en_one)
    |-> counter_reload.load && capture_one_load.load
    ##1 (pin[0] == $past(ctl1.level_two)))
    else $error("pulse trigger did not start the pulse");

  a_pulse_no_flag1: assert property (
    $rose(flag[0]) |-> $past(is_normal))
    else $error("flag one set outside normal mode");

  a_pwm_no_flags: assert property (
    $rose(flag[1]) |-> !$past(is_pwm))
    else $error("flag two set in PWM mode");

  a_pwm_period_end: assert property (
    (period_end && ctl2.pin_en_one)
    |-> counter_reload.load && capture_one_set
    ##1 (pin[0] == $past(ctl1.level_two)) && (active[0] == $past(cmp_val[0])))
    else $error("PWM period end handled wrongly");

  a_pwm_buffer: assert property (
    (is_pwm && !period_end) |=> $stable(active[1]))
    else $error("PWM compare value changed mid period");

  a_pwm_precedence: assert property (
    (ctl2.pwm_select && ctl2.single_pulse_select) |-> is_pwm
    && !capture_one_load.load)
    else $error("pulse mode active beside PWM");

endmodule

// >>> tb/tcp_counter_model.sv
`timescale 1ns/1ps
module tcp_counter_model (
  input wire logic clk,                   // System clock
  input wire logic sys_rst,               // Async reset, high
  input wire tcp_pkg::tcp_load_t preset,  // Bench counter preset
  input wire tcp_pkg::tcp_load_t reload,  // Reload from the block
  input wire logic cap_set,               // Flag one set request
  input wire logic cap_clr,               // Flag one clear by bench
  output logic tick,                      // One timer clock cycle
  output logic [15:0] count,              // Free running count
  output logic cap_flag                   // Capture flag one
);
  // Timer clock on every cycle out of reset
  assign tick = !sys_rst;
  // Counter: bench preset first, then block reload
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      count <= 16'hFFFC;
    end else if (preset.load) begin
      count <= preset.value;
    end else if (reload.load) begin
      count <= reload.value;
    end else begin
      count <= count + 16'h0001;
    end
  end
  // Capture flag one, set wins over clear
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      cap_flag <= 1'b0;
    end else begin
      cap_flag <= cap_set | (cap_flag & !cap_clr);
    end
  end
endmodule

// >>> tb/tb_timer_compare_pulse_pwm.sv
`timescale 1ns/1ps
module tb_timer_compare_pulse_pwm;
  logic clk = 0, sys_rst = 1, psel = 0, penable = 0, pwrite = 0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0000_0000, prdata, rd;
  logic [3:0] pstrb = 4'hF;
  logic pready, pslverr, err, tick, edge1 = 0, cap_flag, cap_clr = 0;
  logic irq_mask = 0, edge_sel, cap_set, cap_dis, irq;
  logic [15:0] count;
  logic [1:0] pin, drive;
  tcp_pkg::tcp_load_t reload, cap_load, preset = '0;
  int miscompares = 0, checked = 0, cyc = 0;

  // 200 MHz clock and cycle count
  always #2.5 clk = ~clk;
  always @(posedge clk) cyc <= cyc + 1;

  tcp_timer_compare u_tcp_timer_compare (.clk(clk), .sys_rst(sys_rst),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .timer_tick(tick), .counter_value(count),
    .capture_pin_one_edge(edge1), .capture_flag_one(cap_flag),
    .irq_mask(irq_mask), .capture_edge_select_one(edge_sel),
    .counter_reload(reload), .capture_one_load(cap_load),
    .capture_one_set(cap_set), .capture_one_disable(cap_dis),
    .compare_output_pin(pin), .compare_pin_drive(drive),
    .timer_irq(irq));

  tcp_counter_model u_tcp_counter_model (.clk(clk), .sys_rst(sys_rst),
    .preset(preset), .reload(reload), .cap_set(cap_set),
    .cap_clr(cap_clr), .tick(tick), .count(count), .cap_flag(cap_flag));

  task finish_test;
    $display("Counts: checked %0d miscompares %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    checked++;
    if (g !== e) begin
      miscompares++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask

  // One APB transfer, held until pready
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    psel <= 1;
    penable <= 0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    rd = prdata;
    err = pslverr;
    psel <= 0;
    penable <= 0;
    if (n >= 50) begin
      miscompares++;
      finish_test;
    end
  endtask

  task set_cnt(input logic [15:0] v);
    @(posedge clk);
    preset <= '{1'b1, v};
    @(posedge clk);
    preset <= '0;
  endtask

  task wait_pin(input logic v);
    int n;
    n = 0;
    while (pin[0] !== v && n < 300) begin
      @(posedge clk);
      #1;
      n++;
    end
    if (n >= 300) begin
      miscompares++;
      finish_test;
    end
  endtask

  task wait_reload(output int t);
    int n;
    n = 0;
    do begin
      @(posedge clk);
      #1;
      n++;
    end while (reload.load !== 1'b1 && n < 1000);
    t = cyc;
    if (n >= 1000) begin
      miscompares++;
      finish_test;
    end
  endtask

  task t_reset;
    for (int i = 0; i < 4; i++) begin
      apb(0, tcp_pkg::OFF_CMP1_HIGH + 8'(4 * i), 0);
      chk("cmp byte", (i % 2 == 0) ? 32'h0000_0080 : 32'h0000_0000, rd);
    end
    chk("pins", 32'h0000_0000, {30'h0, pin});
    apb(0, 8'h1C, 0);
    chk("unmapped err", 32'h0000_0001, {31'h0, err});
    $display("test reset done");
  endtask

  task t_match;
    apb(1, tcp_pkg::OFF_CONTROL_TWO, 32'h0000_0001);
    // Level two high so a disabled pin two would show a wrong level
    apb(1, tcp_pkg::OFF_CONTROL_ONE, 32'h0000_0045);
    apb(1, tcp_pkg::OFF_CMP1_HIGH, 0);
    apb(0, tcp_pkg::OFF_STATUS, 0);
    apb(1, tcp_pkg::OFF_CMP1_LOW, 32'h0000_0040);
    set_cnt(16'h0000);
    wait_pin(1);
    chk("irq", 32'h0000_0001, {31'h0, irq});
    @(posedge clk);
    irq_mask <= 1;
    @(posedge clk);
    #1;
    chk("masked irq", 32'h0000_0000, {31'h0, irq});
    @(posedge clk);
    irq_mask <= 0;
    apb(0, tcp_pkg::OFF_CMP1_LOW, 0);
    apb(0, tcp_pkg::OFF_STATUS, 0);
    chk("flag kept", 32'h0000_0001, rd & 32'h1);
    apb(0, tcp_pkg::OFF_CMP1_LOW, 0);
    apb(0, tcp_pkg::OFF_STATUS, 0);
    chk("flag cleared", 32'h0000_0000, rd & 32'h1);
    $display("test match done");
  endtask

  task t_inhibit;
    apb(1, tcp_pkg::OFF_CMP2_HIGH, 0);
    set_cnt(16'h0000);
    repeat (10) @(posedge clk);
    apb(0, tcp_pkg::OFF_STATUS, 0);
    chk("inhibited", 32'h0000_0000, rd & 32'h2);
    // Short match keeps the count clear of compare one before the reads
    apb(1, tcp_pkg::OFF_CMP2_LOW, 32'h0000_0018);
    set_cnt(16'h0000);
    repeat (30) @(posedge clk);
    apb(0, tcp_pkg::OFF_STATUS, 0);
    chk("flag two", 32'h0000_0002, rd & 32'h2);
    chk("pin two", 32'h0000_0000, {31'h0, pin[1]});
    chk("irq two", 32'h0000_0001, {31'h0, irq});
    apb(0, tcp_pkg::OFF_CMP2_LOW, 0);
    apb(0, tcp_pkg::OFF_CMP1_LOW, 0);
    apb(0, tcp_pkg::OFF_STATUS, 0);
    chk("both cleared", 32'h0000_0000, rd & 32'h3);
    $display("test inhibit done");
  endtask

  task t_force;
    // Compare interrupt enabled so a forced flag would raise the request
    apb(1, tcp_pkg::OFF_CONTROL_ONE, 32'h0000_0048);
    wait_pin(0);
    apb(0, tcp_pkg::OFF_STATUS, 0);
    chk("force flag", 32'h0000_0000, rd & 32'h3);
    chk("force irq", 32'h0000_0000, {31'h0, irq});
    apb(1, tcp_pkg::OFF_CONTROL_TWO, 0);
    apb(1, tcp_pkg::OFF_CONTROL_ONE, 32'h0000_0009);
    repeat (3) @(posedge clk);
    #1;
    chk("force off pin", 32'h0000_0000, {30'h0, pin[0], drive[0]});
    $display("test force done");
  endtask

  task t_pulse;
    // Park the count far from both compare values until the trigger
    set_cnt(16'h1000);
    // Force with level one high: an obeyed force would raise pin one
    apb(1, tcp_pkg::OFF_CONTROL_ONE, 32'h0000_0089);
    apb(1, tcp_pkg::OFF_CONTROL_TWO, 32'h0000_0005);
    apb(1, tcp_pkg::OFF_CMP1_HIGH, 0);
    apb(0, tcp_pkg::OFF_STATUS, 0);
    apb(1, tcp_pkg::OFF_CMP1_LOW, 32'h0000_0010);
    repeat (3) @(posedge clk);
    #1;
    chk("force ignored", 32'h0000_0000, {31'h0, pin[0]});
    chk("cap disable", 32'h0000_0001, {31'h0, cap_dis});
    // Pulse high during, low after
    apb(1, tcp_pkg::OFF_CONTROL_ONE, 32'h0000_0084);
    @(posedge clk);
    edge1 <= 1;
    #1;
    chk("reload", 32'h0001_FFFC, {15'h0, reload});
    chk("cap load", 32'h0001_FFFD, {15'h0, cap_load});
    chk("cap set", 32'h0000_0001, {31'h0, cap_set});
    @(posedge clk);
    edge1 <= 0;
    wait_pin(1);
    chk("cap irq", 32'h0000_0001, {31'h0, irq});
    wait_pin(0);
    apb(0, tcp_pkg::OFF_STATUS, 0);
    chk("no flag one", 32'h0000_0000, rd & 32'h1);
    @(posedge clk);
    cap_clr <= 1;
    @(posedge clk);
    cap_clr <= 0;
    $display("test pulse done");
  endtask

  task t_pwm;
    int a, b, c;
    apb(1, tcp_pkg::OFF_CONTROL_ONE, 32'h0000_0041);
    apb(1, tcp_pkg::OFF_CONTROL_TWO, 32'h0000_000D);
    // Full sequence also clears the timeout flag left by pulse mode
    apb(1, tcp_pkg::OFF_CMP2_HIGH, 0);
    apb(0, tcp_pkg::OFF_STATUS, 0);
    apb(1, tcp_pkg::OFF_CMP2_LOW, 32'h0000_0020);
    set_cnt(16'h0000);
    wait_reload(a);
    chk("pwm reload", 32'h0000_FFFC, {16'h0, reload.value});
    chk("period set", 32'h0000_0001, {31'h0, cap_set});
    wait_reload(a);
    apb(1, tcp_pkg::OFF_CMP2_LOW, 32'h0000_0040);
    wait_reload(b);
    wait_reload(c);
    chk("old period", 32'd37, 32'(b - a));
    chk("new period", 32'd69, 32'(c - b));
    wait_pin(0);
    wait_pin(1);
    apb(0, tcp_pkg::OFF_STATUS, 0);
    chk("pwm flags", 32'h0000_0000, rd & 32'h3);
    chk("pwm irq", 32'h0000_0000, {31'h0, irq});
    $display("test pwm done");
  endtask

  initial begin
    repeat (16) @(posedge clk);
    sys_rst <= 0;
    t_reset();
    t_match();
    t_inhibit();
    t_force();
    t_pulse();
    t_pwm();
    finish_test();
  end
endmodule
